//--- pkg/cpd_pkg.sv
// Constants for the configuration packet decoder
package cpd_pkg;
   // Packet identifiers and fixed payload lengths
   localparam logic [7:0] ID_ALIGN = 8'hb9;
   localparam logic [7:0] ID_FILTER = 8'hba;
   localparam logic [7:0] ID_PIN = 8'hbc;
   localparam logic [7:0] LEN_ALIGN = 8'h49;
   localparam logic [7:0] LEN_FILTER = 8'h11;
   localparam logic [7:0] LEN_PIN = 8'h0d;
   // Payload byte positions
   localparam logic [7:0] OFS_PERSIST = 8'h00;
   localparam logic [7:0] OFS_DCM = 8'h01;
   localparam logic [7:0] OFS_DCM_LAST = 8'h21;
   localparam logic [7:0] OFS_ANT = 8'h25;
   localparam logic [7:0] OFS_ALIGN_RSV = 8'h31;
   localparam logic [7:0] OFS_EXT = 8'h3d;
   localparam logic [7:0] OFS_GNSS_EN = 8'h02;
   localparam logic [7:0] OFS_DEPTH_EN = 8'h04;
   localparam logic [7:0] OFS_MOTION_EN = 8'h07;
   localparam logic [7:0] OFS_PIN1_FN = 8'h01;
   localparam logic [7:0] OFS_PIN2_FN = 8'h02;
   localparam logic [7:0] OFS_TX_FN = 8'h03;
   localparam logic [7:0] OFS_RX_FN = 8'h04;
   localparam logic [7:0] OFS_PIN1_RS232 = 8'h07;
   localparam logic [7:0] OFS_PIN2_RS232 = 8'h08;
   // Byte addresses inside the packet memory
   localparam logic [7:0] BASE_ALIGN = 8'h80;
   localparam logic [7:0] BASE_FILTER = 8'hd0;
   localparam logic [7:0] BASE_PIN = 8'he8;
   localparam logic [7:0] STAGE_MAX = 8'h80;
   // Register byte offsets
   localparam logic [7:0] REG_STAGE = 8'h00;
   localparam logic [7:0] REG_COMMIT = 8'h04;
   localparam logic [7:0] REG_STATUS = 8'h08;
   localparam logic [7:0] REG_RDSEL = 8'h0c;
   localparam logic [7:0] REG_RDDATA = 8'h10;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Reset values of the decoded settings
   localparam logic RST_GNSS_EN = 1'b1;
   localparam logic RST_DEPTH_EN = 1'b1;
   localparam logic RST_MOTION_EN = 1'b0;
   localparam logic [7:0] RST_FN = 8'h00;
   typedef enum logic [1:0] {
      RES_NONE = 2'h0,
      RES_OK = 2'h1,
      RES_BAD_LEN = 2'h2,
      RES_BAD_ID = 2'h3
   } cpd_result_t;
   typedef enum logic [2:0] {
      S_IDLE = 3'b001,
      S_FETCH = 3'b010,
      S_STORE = 3'b100
   } cpd_state_t;
endpackage

//--- hw/cpd_mem.sv
// Byte memory holding the staging area and the stored packet images
`timescale 1ns/10ps
module cpd_mem #(
   parameter int AW = 8,
   parameter int DW = 8
) (
   input wire logic i_mclk,
   input wire logic i_resetn,
   input wire logic i_we,
   input wire logic [AW-1:0] i_waddr,
   input wire logic [DW-1:0] i_wdata,
   input wire logic [AW-1:0] i_raddr,
   output logic [DW-1:0] o_rdata
);
   logic [DW-1:0] mem [0:(1<<AW)-1];

   always_ff @(posedge i_mclk) begin
      if (i_we) begin
         mem[i_waddr] <= i_wdata;
      end
   end

   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_rdata <= '0;
      end else begin
         o_rdata <= mem[i_raddr];
      end
   end
endmodule

//--- hw/cpd_top.sv
// Configuration packet decoder with AXI4-Lite access
`timescale 1ns/10ps
module cpd_top
   import cpd_pkg::*;
#(
   parameter int AW = 8
) (
   input wire logic i_mclk,
   input wire logic i_resetn,
   input wire logic i_awvalid,
   input wire logic [AW-1:0] i_awaddr,
   output logic o_awready,
   input wire logic i_wvalid,
   input wire logic [31:0] i_wdata,
   input wire logic [3:0] i_wstrb,
   output logic o_wready,
   output logic o_bvalid,
   output logic [1:0] o_bresp,
   input wire logic i_bready,
   input wire logic i_arvalid,
   input wire logic [AW-1:0] i_araddr,
   output logic o_arready,
   output logic o_rvalid,
   output logic [31:0] o_rdata,
   output logic [1:0] o_rresp,
   input wire logic i_rready,
   output logic o_gnss_enable,
   output logic o_depth_enable,
   output logic o_motion_enable,
   output logic [7:0] o_pin_one_function,
   output logic [7:0] o_pin_two_function,
   output logic [7:0] o_secondary_port_tx_function,
   output logic [7:0] o_secondary_port_rx_function,
   output logic o_pin_one_rs232,
   output logic o_pin_two_rs232,
   output logic o_pin_one_input,
   output logic o_flash_save,
   output logic [7:0] o_flash_id
);
   ////////////////////////////////////////////////////////////////////////////
   cpd_state_t state;
   cpd_result_t result;
   logic [7:0] stage_cnt;
   logic [7:0] cur_id;
   logic [7:0] cur_last;
   logic [7:0] idx;
   logic persist;
   logic [7:0] sel_id;
   logic [7:0] sel_ofs;
   logic [AW-1:0] rd_addr;
   logic rd_act;
   logic rd_wait;
   logic rd_err;
   logic [7:0] mem_rdata;
   wire busy = (state != S_IDLE);
   wire wr_fire = o_awready & o_wready;
   wire rd_fire = o_arready & i_arvalid;
   wire [7:0] waddr8 = 8'(i_awaddr);
   wire [7:0] raddr8 = 8'(rd_addr);
   wire wr_stage = wr_fire & (waddr8 == REG_STAGE) & i_wstrb[0];
   wire wr_commit = wr_fire & (waddr8 == REG_COMMIT) & i_wstrb[0];
   wire wr_rdsel = wr_fire & (waddr8 == REG_RDSEL);
   wire wr_known = (waddr8 == REG_STAGE) | (waddr8 == REG_COMMIT) | (waddr8 == REG_RDSEL);
   wire rd_is_data = (raddr8 == REG_RDDATA);
   wire rd_known = rd_is_data | (raddr8 == REG_STAGE) | (raddr8 == REG_STATUS)
      | (raddr8 == REG_RDSEL);

   ////////////////////////////////////////////////////////////////////////////
   // Packet identity to fixed length and memory base
   function automatic logic [7:0] len_of(input logic [7:0] id);
      case (id)
         ID_ALIGN: len_of = LEN_ALIGN;
         ID_FILTER: len_of = LEN_FILTER;
         ID_PIN: len_of = LEN_PIN;
         default: len_of = 8'h00;
      endcase
   endfunction
   function automatic logic [7:0] base_of(input logic [7:0] id);
      case (id)
         ID_ALIGN: base_of = BASE_ALIGN;
         ID_FILTER: base_of = BASE_FILTER;
         default: base_of = BASE_PIN;
      endcase
   endfunction
   wire [7:0] cmt_id = i_wdata[7:0];
   wire [7:0] cmt_len = len_of(cmt_id);
   wire cmt_known = (cmt_len != 8'h00);
   wire cmt_len_ok = (stage_cnt == cmt_len);
   wire [7:0] sel_len = len_of(sel_id);
   wire sel_ok = (sel_len != 8'h00) & (sel_ofs < sel_len);

   ////////////////////////////////////////////////////////////////////////////
   // Field classification of the byte being stored
   wire st_align = (state == S_STORE) & (cur_id == ID_ALIGN);
   wire st_filter = (state == S_STORE) & (cur_id == ID_FILTER);
   wire st_pin = (state == S_STORE) & (cur_id == ID_PIN);
   wire in_dcm = (idx >= OFS_DCM) & (idx < OFS_ANT);
   wire in_ant = (idx >= OFS_ANT) & (idx < OFS_ALIGN_RSV);
   wire in_rsv = (idx >= OFS_ALIGN_RSV) & (idx < OFS_EXT);
   wire [7:0] p1 = mem_rdata;
   wire p1_ok = (p1 == 8'h00) | (p1 == 8'h01) | (p1 == 8'h02) | (p1 == 8'h04)
      | (p1 == 8'h07) | (p1 == 8'h0c)
      | (p1 == 8'h0e) | (p1 == 8'h0f) | (p1 == 8'h10)
      | (p1 == 8'h11)
      | (p1 == 8'h12) | (p1 == 8'h1d) | (p1 == 8'h21) | (p1 == 8'h22);
   wire p1_in = (p1 == 8'h04) | ((p1 >= 8'h0e) & (p1 <= 8'h12))
      | (p1 == 8'h1d) | (p1 == 8'h21) | (p1 == 8'h22);
   wire p1_keep = st_pin & (idx == OFS_PIN1_FN) & ~p1_ok;
   wire [7:0] st_data = (st_align & in_rsv) ? 8'h00
      : p1_keep ? o_pin_one_function : mem_rdata;
   wire st_last = (state == S_STORE) & (idx == cur_last);
   // Memory ports; software data reads wait while a commit walk runs since the walk owns the read port
   wire stage_we = wr_stage & (stage_cnt < STAGE_MAX);
   wire mem_we = stage_we | (state == S_STORE);
   wire [7:0] mem_waddr = stage_we ? stage_cnt : 8'(base_of(cur_id) + idx);
   wire [7:0] mem_wdata = stage_we ? i_wdata[7:0] : st_data;
   wire [7:0] mem_raddr = busy ? idx : 8'(base_of(sel_id) + sel_ofs);
   cpd_mem #(.AW(8), .DW(8)) u_mem (
      .i_mclk(i_mclk),
      .i_resetn(i_resetn),
      .i_we(mem_we),
      .i_waddr(mem_waddr),
      .i_wdata(mem_wdata),
      .i_raddr(mem_raddr),
      .o_rdata(mem_rdata)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Write channel: address and data are taken together
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_awready <= 1'b0;
         o_wready <= 1'b0;
         o_bvalid <= 1'b0;
         o_bresp <= RESP_OKAY;
      end else begin
         o_awready <= i_awvalid & i_wvalid & ~o_awready & ~o_bvalid & ~busy;
         o_wready <= i_awvalid & i_wvalid & ~o_awready & ~o_bvalid & ~busy;
         if (wr_fire) begin
            o_bvalid <= 1'b1;
            o_bresp <= wr_known ? RESP_OKAY : RESP_SLVERR;
         end else if (i_bready) begin
            o_bvalid <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read channel
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_arready <= 1'b0;
         o_rvalid <= 1'b0;
         o_rdata <= '0;
         o_rresp <= RESP_OKAY;
         rd_addr <= '0;
         rd_act <= 1'b0;
         rd_wait <= 1'b0;
         rd_err <= 1'b0;
      end else begin
         o_arready <= i_arvalid & ~o_arready & ~rd_act & ~rd_wait & ~o_rvalid;
         if (rd_fire) begin
            rd_addr <= i_araddr;
            rd_act <= 1'b1;
         end
         if (rd_act & rd_is_data & ~busy) begin
            rd_act <= 1'b0;
            rd_wait <= 1'b1;
            rd_err <= ~sel_ok;
         end else if (rd_act & ~rd_is_data) begin
            rd_act <= 1'b0;
            o_rvalid <= 1'b1;
            o_rresp <= rd_known ? RESP_OKAY : RESP_SLVERR;
            case (raddr8)
               REG_STAGE: o_rdata <= {24'h000000, stage_cnt};
               REG_STATUS: o_rdata <= {8'h00, stage_cnt, cur_id, 5'h00, result, busy};
               REG_RDSEL: o_rdata <= {16'h0000, sel_ofs, sel_id};
               default: o_rdata <= 32'h00000000;
            endcase
         end
         if (rd_wait) begin
            rd_wait <= 1'b0;
            o_rvalid <= 1'b1;
            o_rresp <= rd_err ? RESP_SLVERR : RESP_OKAY;
            o_rdata <= rd_err ? 32'h00000000 : {24'h000000, mem_rdata};
         end else if (o_rvalid & i_rready) begin
            o_rvalid <= 1'b0;
         end
      end
   end

   // Read-back selector; the offset steps on each data read for byte streaming
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         sel_id <= 8'h00;
         sel_ofs <= 8'h00;
      end else if (wr_rdsel) begin
         if (i_wstrb[0]) begin
            sel_id <= i_wdata[7:0];
         end
         if (i_wstrb[1]) begin
            sel_ofs <= i_wdata[15:8];
         end
      end else if (rd_wait) begin
         sel_ofs <= sel_ofs + 8'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Commit walk: checks, then copies the staged bytes into the stored image
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         state <= S_IDLE;
         result <= RES_NONE;
         stage_cnt <= 8'h00;
         cur_id <= 8'h00;
         cur_last <= 8'h00;
         idx <= 8'h00;
      end else begin
         case (state)
            S_IDLE: begin
               if (stage_we) begin
                  stage_cnt <= stage_cnt + 8'h01;
               end
               if (wr_commit) begin
                  stage_cnt <= 8'h00;
                  cur_id <= cmt_id;
                  cur_last <= cmt_len - 8'h01;
                  idx <= 8'h00;
                  if (!cmt_known) begin
                     result <= RES_BAD_ID;
                  end else if (!cmt_len_ok) begin
                     result <= RES_BAD_LEN;
                  end else begin
                     state <= S_FETCH;
                  end
               end
            end
            S_FETCH: begin
               state <= S_STORE;
            end
            S_STORE: begin
               if (st_last) begin
                  state <= S_IDLE;
                  result <= RES_OK;
               end else begin
                  idx <= idx + 8'h01;
                  state <= S_FETCH;
               end
            end
            default: begin
               state <= S_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Decoded settings taken from the bytes as they are stored
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_gnss_enable <= RST_GNSS_EN;
         o_depth_enable <= RST_DEPTH_EN;
         o_motion_enable <= RST_MOTION_EN;
         o_pin_one_function <= RST_FN;
         o_pin_two_function <= RST_FN;
         o_secondary_port_tx_function <= RST_FN;
         o_secondary_port_rx_function <= RST_FN;
         o_pin_one_rs232 <= 1'b0;
         o_pin_two_rs232 <= 1'b0;
         o_pin_one_input <= 1'b0;
      end else begin
         if (st_filter & (idx == OFS_GNSS_EN)) begin
            o_gnss_enable <= (mem_rdata != 8'h00);
         end
         if (st_filter & (idx == OFS_DEPTH_EN)) begin
            o_depth_enable <= (mem_rdata != 8'h00);
         end
         if (st_filter & (idx == OFS_MOTION_EN)) begin
            o_motion_enable <= (mem_rdata != 8'h00);
         end
         if (st_pin & (idx == OFS_PIN1_FN) & p1_ok) begin
            o_pin_one_function <= p1;
            o_pin_one_input <= p1_in;
         end
         if (st_pin & (idx == OFS_PIN2_FN)) begin
            o_pin_two_function <= mem_rdata;
         end
         if (st_pin & (idx == OFS_TX_FN)) begin
            o_secondary_port_tx_function <= mem_rdata;
         end
         if (st_pin & (idx == OFS_RX_FN)) begin
            o_secondary_port_rx_function <= mem_rdata;
         end
         if (st_pin & (idx == OFS_PIN1_RS232)) begin
            o_pin_one_rs232 <= (mem_rdata != 8'h00);
         end
         if (st_pin & (idx == OFS_PIN2_RS232)) begin
            o_pin_two_rs232 <= (mem_rdata != 8'h00);
         end
      end
   end

   // Persistence request leaves as a pulse once the whole image is stored
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         persist <= 1'b0;
         o_flash_save <= 1'b0;
         o_flash_id <= 8'h00;
      end else begin
         if ((state == S_STORE) & (idx == OFS_PERSIST)) begin
            persist <= (mem_rdata == 8'h01);
         end
         o_flash_save <= st_last & persist;
         if (st_last & persist) begin
            o_flash_id <= cur_id;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   chk_commit_done: assert property (@(posedge i_mclk) disable iff (!i_resetn)
      st_last |=> (result == RES_OK) && (state == S_IDLE))
      else $error("commit walk did not finish with success");
   chk_reject_len: assert property (@(posedge i_mclk) disable iff (!i_resetn)
      (wr_commit && cmt_known && !cmt_len_ok && !busy) |=> (result == RES_BAD_LEN)
         && (state == S_IDLE) && $stable(o_pin_one_function))
      else $error("wrong length packet was not rejected");
   chk_pin_keep: assert property (@(posedge i_mclk) disable iff (!i_resetn)
      p1_keep |=> $stable(o_pin_one_function) ##1 $stable(o_pin_one_function))
      else $error("unlisted pin function code was taken");
   chk_gnss_enable: assert property (@(posedge i_mclk) disable iff (!i_resetn)
      (st_filter && idx == OFS_GNSS_EN) |=> (o_gnss_enable == ($past(mem_rdata) != 8'h00)))
      else $error("receiver enable does not follow byte two");
   chk_align_rsv: assert property (@(posedge i_mclk) disable iff (!i_resetn)
      (st_align && idx >= OFS_ALIGN_RSV && idx < OFS_EXT) |-> mem_we && (mem_wdata == 8'h00))
      else $error("reserved alignment byte stored non-zero");
   chk_flash_pulse: assert property (@(posedge i_mclk) disable iff (!i_resetn)
      o_flash_save |-> $past(st_last) && (o_flash_id == $past(cur_id)) ##1 !o_flash_save)
      else $error("flash request not a single pulse after commit");
   chk_bresp_hold: assert property (@(posedge i_mclk) disable iff (!i_resetn)
      (o_bvalid && !i_bready) |=> o_bvalid && $stable(o_bresp))
      else $error("write response dropped before acceptance");
   chk_read_answer: assert property (@(posedge i_mclk) disable iff (!i_resetn)
      rd_fire |-> ##[1:300] o_rvalid)
      else $error("read request got no answer");
   chk_dcm_copy: assert property (@(posedge i_mclk) disable iff (!i_resetn)
      (st_align && (in_dcm || in_ant)) |-> mem_we && (mem_waddr == 8'(BASE_ALIGN + idx))
         && (mem_wdata == mem_rdata))
      else $error("matrix or lever arm byte not copied in place");
endmodule

//--- dv/cpd_host_model.sv
// Host model sending configuration packets over AXI4-Lite
`timescale 1ns/10ps
module cpd_host_model
   import cpd_pkg::*;
(
   input wire logic i_mclk,
   output logic o_awvalid,
   output logic [7:0] o_awaddr,
   input wire logic i_awready,
   output logic o_wvalid,
   output logic [31:0] o_wdata,
   output logic [3:0] o_wstrb,
   input wire logic i_wready,
   input wire logic i_bvalid,
   input wire logic [1:0] i_bresp,
   output logic o_bready,
   output logic o_arvalid,
   output logic [7:0] o_araddr,
   input wire logic i_arready,
   input wire logic i_rvalid,
   input wire logic [31:0] i_rdata,
   input wire logic [1:0] i_rresp,
   output logic o_rready
);
   // Payload image, byte 0 is the persistence flag
   logic [7:0] pb [0:127];
   initial {o_awvalid, o_awaddr, o_wvalid, o_wdata, o_wstrb, o_bready} = '0;
   initial {o_arvalid, o_araddr, o_rready} = '0;
   //////////////////////////////////////////////////////////////////////////
   // Each channel is released only at the edge that takes it
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic aw_done;
      logic w_done;
      @(posedge i_mclk);
      o_awvalid <= 1'b1;
      o_awaddr <= a;
      o_wvalid <= 1'b1;
      o_wdata <= d;
      o_wstrb <= 4'hf;
      o_bready <= 1'b1;
      aw_done = 1'b0;
      w_done = 1'b0;
      while (!(aw_done && w_done)) begin
         @(posedge i_mclk);
         if (o_awvalid && i_awready === 1'b1) begin
            aw_done = 1'b1;
            o_awvalid <= 1'b0;
         end
         if (o_wvalid && i_wready === 1'b1) begin
            w_done = 1'b1;
            o_wvalid <= 1'b0;
         end
      end
      while (i_bvalid !== 1'b1)
         @(posedge i_mclk);
      r = i_bresp;
      o_bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge i_mclk);
      o_arvalid <= 1'b1;
      o_araddr <= a;
      o_rready <= 1'b1;
      do
         @(posedge i_mclk);
      while (i_arready !== 1'b1);
      o_arvalid <= 1'b0;
      while (i_rvalid !== 1'b1)
         @(posedge i_mclk);
      d = i_rdata;
      r = i_rresp;
      o_rready <= 1'b0;
   endtask
   //////////////////////////////////////////////////////////////////////////
   // Matrix goes as ready floats, never as angles
   task automatic send(input logic [7:0] id, input int n, output logic [31:0] st);
      logic [1:0] r;
      for (int i = 0; i < n; i++)
         wr(REG_STAGE, {24'h0, pb[i]}, r);
      wr(REG_COMMIT, {24'h0, id}, r);
      st = 32'h1;
      while (st[0] !== 1'b0)
         rd(REG_STATUS, st, r);
   endtask
endmodule

//--- dv/config_packet_decoder_tb_top.sv
// Self-checking testbench of the configuration packet decoder
`timescale 1ns/10ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin fail_count++; \
   $display("ERROR t=%0t got=%h exp=%h", $time, (a), (e)); end end
module config_packet_decoder_tb_top
   import cpd_pkg::*;
;
   logic i_mclk, i_resetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, gnss, depth, motion, rs1, rs2, pin_in, fsave;
   logic [7:0] awaddr, araddr, fn1, fn2, txf, rxf, fid, fcnt;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp;
   int fail_count = 0;
   int cmp_count = 0;
   cpd_top dut (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_awvalid(awvalid),
      .i_awaddr(awaddr), .o_awready(awready), .i_wvalid(wvalid), .i_wdata(wdata),
      .i_wstrb(wstrb), .o_wready(wready), .o_bvalid(bvalid), .o_bresp(bresp),
      .i_bready(bready), .i_arvalid(arvalid), .i_araddr(araddr), .o_arready(arready),
      .o_rvalid(rvalid), .o_rdata(rdata), .o_rresp(rresp), .i_rready(rready),
      .o_gnss_enable(gnss), .o_depth_enable(depth), .o_motion_enable(motion),
      .o_pin_one_function(fn1), .o_pin_two_function(fn2),
      .o_secondary_port_tx_function(txf), .o_secondary_port_rx_function(rxf),
      .o_pin_one_rs232(rs1), .o_pin_two_rs232(rs2), .o_pin_one_input(pin_in),
      .o_flash_save(fsave), .o_flash_id(fid));
   cpd_host_model h (.i_mclk(i_mclk), .o_awvalid(awvalid), .o_awaddr(awaddr),
      .i_awready(awready), .o_wvalid(wvalid), .o_wdata(wdata), .o_wstrb(wstrb),
      .i_wready(wready), .i_bvalid(bvalid), .i_bresp(bresp), .o_bready(bready),
      .o_arvalid(arvalid), .o_araddr(araddr), .i_arready(arready), .i_rvalid(rvalid),
      .i_rdata(rdata), .i_rresp(rresp), .o_rready(rready));
   initial begin
      i_mclk = 1'b0;
      forever #5 i_mclk = ~i_mclk;
   end
   always @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn)
         fcnt <= 8'h00;
      else if (fsave === 1'b1)
         fcnt <= fcnt + 8'h01;
   end
   //////////////////////////////////////////////////////////////////////////
   task automatic clr();
      for (int i = 0; i < 128; i++)
         h.pb[i] = 8'h00;
   endtask
   task automatic pkt(input logic [7:0] id, input int n, input logic [1:0] res);
      logic [31:0] st;
      h.send(id, n, st);
      `CHK(st[2:1], res)
   endtask
   // Reads one byte past the end to hit the length limit
   task automatic rback(input logic [7:0] id, input int n);
      logic [31:0] d;
      logic [1:0] r;
      h.wr(REG_RDSEL, {24'h0, id}, r);
      for (int i = 0; i <= n; i++) begin
         h.rd(REG_RDDATA, d, r);
         if (i < n) begin
            `CHK(d[7:0], h.pb[i])
         end else begin
            `CHK(r, RESP_SLVERR)
         end
      end
   endtask
   //////////////////////////////////////////////////////////////////////////
   task automatic s_reset();
      `CHK({gnss, depth, motion, fn1, rs1, fcnt}, {3'b110, 8'h00, 1'b0, 8'h00})
   endtask
   task automatic s_filter();
      clr();
      h.pb[0] = 8'h01;
      h.pb[4] = 8'h01;
      h.pb[7] = 8'h01;
      pkt(ID_FILTER, 17, 2'h1);
      repeat (2) @(posedge i_mclk);
      `CHK({gnss, depth, motion}, 3'b011)
      `CHK({fcnt, fid}, {8'h01, ID_FILTER})
      rback(ID_FILTER, 17);
      h.pb[0] = 8'h00;
      h.pb[2] = 8'h01;
      h.pb[7] = 8'h00;
      pkt(ID_FILTER, 17, 2'h1);
      repeat (2) @(posedge i_mclk);
      `CHK({gnss, depth, motion, fcnt}, {3'b110, 8'h01})
   endtask
   task automatic s_align();
      clr();
      for (int i = 1; i < 73; i++)
         h.pb[i] = (i >= 49 && i < 61) ? 8'h00 : 8'(i * 3 + 1);
      pkt(ID_ALIGN, 73, 2'h1);
      rback(ID_ALIGN, 73);
   endtask
   task automatic s_pin();
      logic [7:0] codes [14] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h07, 8'h0c, 8'h0e,
         8'h0f, 8'h10, 8'h11, 8'h12, 8'h1d, 8'h21, 8'h22};
      logic [7:0] c;
      logic ein;
      for (int k = 0; k < 14; k++) begin
         c = codes[k];
         ein = c == 8'h04 || (c >= 8'h0e && c <= 8'h12) || c >= 8'h1d;
         clr();
         h.pb[1] = c;
         h.pb[2] = 8'(k);
         h.pb[3] = 8'h07;
         h.pb[4] = 8'h09;
         h.pb[7] = {7'h0, k[0]};
         h.pb[8] = {7'h0, ~k[0]};
         pkt(ID_PIN, 13, 2'h1);
         `CHK({fn1, pin_in}, {c, ein})
         `CHK({fn2, txf, rxf}, {8'(k), 16'h0709})
         `CHK({rs1, rs2}, {k[0], ~k[0]})
      end
   endtask
   task automatic s_reject();
      h.pb[1] = 8'h03;
      h.pb[2] = 8'h25;
      pkt(ID_PIN, 13, 2'h1);
      `CHK({fn1, fn2}, 16'h2225)
      // The stored image keeps the previous pin one code
      h.pb[1] = 8'h22;
      rback(ID_PIN, 13);
      h.pb[1] = 8'h01;
      h.pb[2] = 8'h01;
      pkt(ID_PIN, 12, 2'h2);
      pkt(8'hbb, 13, 2'h3);
      // Receiver byte zero so that a wrongly taken packet would show
      h.pb[2] = 8'h00;
      pkt(ID_FILTER, 18, 2'h2);
      `CHK({fn1, fn2, gnss}, {16'h2225, 1'b1})
   endtask
   task automatic s_bus();
      logic [31:0] d;
      logic [1:0] r;
      h.rd(REG_RDSEL, d, r);
      `CHK({r, d}, {RESP_OKAY, 32'h00000ebc})
      h.rd(REG_STATUS, d, r);
      `CHK({r, d}, {RESP_OKAY, 32'h0000ba04})
      h.rd(8'h40, d, r);
      `CHK({r, d}, {RESP_SLVERR, 32'h0})
      h.wr(8'h44, 32'h1, r);
      `CHK(r, RESP_SLVERR)
   endtask
   //////////////////////////////////////////////////////////////////////////
   task automatic results();
      if (fail_count == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      i_resetn = 1'b0;
      repeat (10) @(posedge i_mclk);
      i_resetn <= 1'b1;
      s_reset();
      s_filter();
      s_align();
      s_pin();
      s_reject();
      s_bus();
      results();
   end
   // Whole run needs about 2800 cycles
   initial begin
      repeat (60000) @(posedge i_mclk);
      fail_count++;
      results();
   end
endmodule
